// File: dv/fetch_execute_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "fetch_execute_sequencer_params.svh"
module fes_checker
  import fetch_execute_sequencer_pkg::*;
(
  input wire logic                                   i_clk,
  input wire logic                                   i_resetn,
  input wire logic                                   i_ce,
  input wire logic [`FES_PC_WIDTH-1:0]               o_pmem_addr,
  input wire logic                                   o_pmem_fetch,
  input wire logic [`FES_INSTR_WIDTH-1:0]            o_exec_instr,
  input wire logic                                   o_exec_valid,
  input wire fetch_execute_sequencer_pkg::exec_req_s i_exec_req,
  input wire logic [`FES_DATA_WIDTH-1:0]             o_pcl,
  input wire logic [`FES_PHASES-1:0]                 o_phase,
  input wire logic                                   o_cycle_start
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_phase_onehot: assert property ($onehot(o_phase))
    else $error("phase strobes not one-hot");
  a_phase_rotate: assert property (i_ce |=> o_phase ==
    {$past(o_phase[2:0]), $past(o_phase[3])}) else $error("phase order");
  a_fetch_in_t1: assert property (o_cycle_start == o_phase[0] &&
    o_pmem_fetch == (o_phase[0] && i_ce)) else $error("fetch outside t1");
  a_pc_hold: assert property (!(i_ce && o_phase[0]) |=>
    $stable(o_pmem_addr)) else $error("pc moved outside t1");
  a_pc_step: assert property (i_ce && o_phase[0] && o_exec_valid |=>
    o_pmem_addr == $past(o_pmem_addr) + 11'h001) else $error("pc step");
  a_instr_hold: assert property (!(i_ce && o_phase[0]) |=>
    $stable(o_exec_instr)) else $error("slot changed mid cycle");
  a_pcl_low: assert property (o_pcl == o_pmem_addr[7:0])
    else $error("pcl differs from pc");
  a_jump_load: assert property (i_ce && o_phase[3] && o_exec_valid &&
    i_exec_req.flow == FLOW_JUMP |=> ##1 !o_exec_valid &&
    o_pmem_addr == $past(i_exec_req.target, 2)) else $error("jump load");
  a_reset_pc: assert property ($rose(i_resetn) |->
    o_pmem_addr == `FES_PC_RESET) else $error("pc after reset");
  c_jump: cover property (o_phase[3] && o_exec_valid &&
    i_exec_req.flow == FLOW_JUMP);
  c_skip: cover property (o_phase[3] && o_exec_valid &&
    i_exec_req.flow == FLOW_SKIP && i_exec_req.skip_cond);
  c_stall: cover property (!i_ce && o_exec_valid);
endmodule
bind fetch_execute_sequencer fes_checker fes_checker_i (.*);
`default_nettype wire

// File: dv/fetch_execute_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fetch_execute_sequencer_params.svh"
module fetch_execute_sequencer_tb;
  import fetch_execute_sequencer_pkg::*;
  logic        i_clk = 0, i_resetn = 0, i_ce = 1, o_pmem_fetch, o_exec_valid;
  logic        o_cycle_start;
  logic [10:0] o_pmem_addr, epc, nxt, stk[$];
  logic [15:0] i_pmem_data, o_exec_instr, w, exq[$];
  logic [7:0]  o_acc, o_pcl, b, res, ea, eaq[$], eacc = 8'h00;
  logic [3:0]  o_phase, lph = 0;
  exec_req_s   i_exec_req;
  flow_e       f;
  integer      seed = 51695, r, n_errors = 0, n_checks = 0, cyc = 0, mix = 1;
  always #2.5 i_clk = ~i_clk;
  fetch_execute_sequencer fetch_execute_sequencer_i (.*);
  pmem_model pmem_model_i (.i_clk(i_clk), .i_addr(o_pmem_addr),
    .i_fetch(o_pmem_fetch), .o_data(i_pmem_data));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Reference ALU: accumulator and operand in, result out
  function automatic logic [7:0] alu_model(input alu_op_e op,
      input logic [7:0] a, input logic [7:0] b);
    case (op)
      ALU_ADD: return a + b;
      ALU_SUB: return a - b;
      ALU_AND: return a & b;
      ALU_OR:  return a | b;
      ALU_XOR: return a ^ b;
      ALU_RL:  return {b[6:0], b[7]};
      ALU_RR:  return {b[0], b[7:1]};
      default: return b + 8'h01;
    endcase
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Decoder stand-in: decides each flow and notes the word due next
  always @(negedge i_clk) begin
    i_ce = mix ? 1'b1 : ($random(seed) % 4 != 0);
    if (i_resetn && i_ce && o_phase[3] && o_exec_valid) begin
      r = $random(seed);
      f = FLOW_SEQ;
      if (mix) f = flow_e'(r[23:21] == 3'h7 ? 3'h0 : r[23:21]);
      // Keep the return stack inside its depth
      if ((f == FLOW_CALL || f == FLOW_INT) && stk.size() == 4) f = FLOW_SEQ;
      if (f == FLOW_RET && stk.size() == 0) f = FLOW_SEQ;
      nxt = epc + 11'h001;
      // Counter low byte read sees the address past this instruction
      b = r[20] ? nxt[7:0] : r[18:11];
      res = alu_model(alu_op_e'(r[26:24]), eacc, b);
      case (f)
        FLOW_JUMP: nxt = r[10:0];
        FLOW_CALL, FLOW_INT: begin
          stk.push_back(nxt);
          nxt = r[10:0];
        end
        FLOW_RET: nxt = stk.pop_back();
        FLOW_SKIP: if (r[19]) nxt = epc + 11'h002;
        FLOW_PCLW: nxt[7:0] = res;
        default: ;
      endcase
      i_exec_req = '{flow: f, target: r[10:0], skip_cond: r[19],
        alu_op: alu_op_e'(r[26:24]), operand: r[18:11], acc_write: r[27],
        pcl_read: r[20]};
      if (r[27]) eacc = res;
      epc = nxt;
      exq.push_back({5'h15, nxt});
      eaq.push_back(eacc);
    end
  end
  // Watcher: three compares (word, counter low byte, accumulator) per instruction entering the execute slot
  always @(negedge i_clk) begin
    if (o_phase[1] && o_exec_valid && lph != o_phase && exq.size() > 0) begin
      w = exq.pop_front();
      ea = eaq.pop_front();
      check(o_exec_instr, w);
      check({8'h00, o_pcl}, {8'h00, w[7:0] + 8'h01});
      check({8'h00, o_acc}, {8'h00, ea});
    end
    lph = o_phase;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    i_exec_req = '0;
    epc = 11'h000;
    exq.push_back({5'h15, 11'h000});
    eaq.push_back(8'h00);
    repeat (12) @(negedge i_clk);
    i_resetn = 1;
    repeat (2400) @(negedge i_clk);
    @(negedge i_clk iff o_phase[1]);
    $display("test mixed flows done");
    mix = 0;
    repeat (1200) @(negedge i_clk);
    $display("test stalled sequential done");
    give_verdict();
  end
endmodule
`default_nettype wire

// File: dv/pmem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmem_model (
  input  wire logic        i_clk,
  input  wire logic [10:0] i_addr,
  input  wire logic        i_fetch,
  output logic      [15:0] o_data
);
  logic [15:0] last;
  always_ff @(posedge i_clk) last <= o_data;
  // Word carries its address; toggles when unread so stale data shows
  assign o_data = i_fetch ? {5'h15, i_addr} : ~last;
endmodule
`default_nettype wire

// File: logic/fetch_execute_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "fetch_execute_sequencer_params.svh"

// Function
// RULE1: Four non-overlapping phase strobes derived from the system clock.
// RULE2: Counter advances at phase one start, fetch happens in phase one; the counter here steps on the clock that ends phase one, after the fetch.
// RULE3: Phases two to four decode and execute the previously fetched word.
// RULE4: One pass through all four phases is one instruction cycle.
// RULE5: Fetch overlaps execute, giving one instruction per cycle when sequential.
// RULE6: Non-sequential counter changes cost one extra instruction cycle.
// RULE7: Sequentially the counter increments by one per executed instruction.
// RULE8: Jumps, calls, interrupts and reset load target address directly.
// RULE9: Satisfied skip discards prefetched word and runs a dummy cycle.
// RULE10: Only the low eight counter bits are software readable and writable.
// RULE11: Execute uses an eight-bit ALU for arithmetic, logic, rotate, step.
// RULE12: Execute data moves through the accumulator and the ALU.
// RULE13: Low byte write jumps within current 256-word page plus dummy cycle.
// RULE14: Calls and interrupts push counter on return stack; returns pop.
// RULE15: Eleven-bit counter covering 2K words, cleared on reset.
module fetch_execute_sequencer
  import fetch_execute_sequencer_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                                   i_clk,
  input  wire logic                                   i_resetn,
  input  wire logic                                   i_ce,
  // Program memory
  output logic [`FES_PC_WIDTH-1:0]                    o_pmem_addr,
  output logic                                        o_pmem_fetch,
  input  wire logic [`FES_INSTR_WIDTH-1:0]            i_pmem_data,
  // Decoder and datapath
  output logic [`FES_INSTR_WIDTH-1:0]                 o_exec_instr,
  output logic                                        o_exec_valid,
  input  wire fetch_execute_sequencer_pkg::exec_req_s i_exec_req,
  output logic [`FES_DATA_WIDTH-1:0]                  o_acc,
  output logic [`FES_DATA_WIDTH-1:0]                  o_pcl,
  // Phase strobes
  output logic [`FES_PHASES-1:0]                      o_phase,
  output logic                                        o_cycle_start
);
  import fetch_execute_sequencer_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Phase generator
  phase_e phase;
  phase_e next_phase;

  always_comb begin
    unique case (phase)
      PH_T1: next_phase = PH_T2;
      PH_T2: next_phase = PH_T3;
      PH_T3: next_phase = PH_T4;
      PH_T4: next_phase = PH_T1; // RULE4
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter, fetch slot, return stack, accumulator
  logic [`FES_PC_WIDTH-1:0]    pc;
  logic [`FES_PC_WIDTH-1:0]    next_pc;
  logic [`FES_INSTR_WIDTH-1:0] instr;
  logic [`FES_INSTR_WIDTH-1:0] next_instr;
  logic                        valid;
  logic                        next_valid;
  logic                        dummy;
  logic                        next_dummy;
  logic [`FES_PC_WIDTH-1:0]    redirect;
  logic [`FES_PC_WIDTH-1:0]    next_redirect;
  logic [`FES_PC_WIDTH-1:0]    stack [`FES_STACK_DEPTH];
  logic [`FES_PC_WIDTH-1:0]    next_stack [`FES_STACK_DEPTH];
  logic [`FES_SP_WIDTH-1:0]    sp;
  logic [`FES_SP_WIDTH-1:0]    next_sp;
  logic [`FES_DATA_WIDTH-1:0]  acc;
  logic [`FES_DATA_WIDTH-1:0]  next_acc;
  logic [`FES_DATA_WIDTH-1:0]  alu_a;
  logic [`FES_DATA_WIDTH-1:0]  alu_y;
  logic                        exec_now;
  logic                        take_break;
  logic [`FES_SP_WIDTH-1:0]    sp_dec;

  assign sp_dec = sp - `FES_SP_WIDTH'(1);
  // Decision sampled in the last phase so decoder has T2..T4 to settle
  assign exec_now = (phase == PH_T4) && valid && !dummy; // RULE3

  // Eight-bit ALU; accumulator is one operand of add, subtract, and, or, xor, path back into it
  always_comb begin
    alu_a = i_exec_req.pcl_read ? pc[7:0] : i_exec_req.operand; // RULE10
    unique case (i_exec_req.alu_op)
      ALU_ADD: alu_y = acc + alu_a; // RULE11
      ALU_SUB: alu_y = acc - alu_a;
      ALU_AND: alu_y = acc & alu_a;
      ALU_OR:  alu_y = acc | alu_a;
      ALU_XOR: alu_y = acc ^ alu_a;
      ALU_RL:  alu_y = {alu_a[6:0], alu_a[7]};
      ALU_RR:  alu_y = {alu_a[0], alu_a[7:1]};
      ALU_INC: alu_y = alu_a + 8'h01;
    endcase
  end

  always_comb begin
    next_pc       = pc;
    next_instr    = instr;
    next_valid    = valid;
    next_dummy    = dummy;
    next_redirect = redirect;
    next_stack    = stack;
    next_sp       = sp;
    next_acc      = acc;
    take_break    = 1'b0;
    if (exec_now) begin
      if (i_exec_req.acc_write)
        next_acc = alu_y; // RULE12
      unique case (i_exec_req.flow)
        FLOW_SEQ: take_break = 1'b0;
        FLOW_JUMP: begin
          take_break    = 1'b1;
          next_redirect = i_exec_req.target; // RULE8
        end
        FLOW_CALL, FLOW_INT: begin
          take_break     = 1'b1;
          next_redirect  = i_exec_req.target; // RULE8
          next_stack[sp] = pc; // RULE14
          next_sp        = sp + `FES_SP_WIDTH'(1);
        end
        FLOW_RET: begin
          take_break    = 1'b1;
          next_redirect = stack[sp_dec]; // RULE14
          next_sp       = sp_dec;
        end
        FLOW_SKIP: begin
          take_break    = i_exec_req.skip_cond; // RULE9
          next_redirect = pc + `FES_PC_WIDTH'(1);
        end
        FLOW_PCLW: begin
          take_break    = 1'b1;
          next_redirect = {pc[10:8], alu_y}; // RULE13
        end
        default: take_break = 1'b0;
      endcase
    end
    if (phase == PH_T4) begin
      if (take_break)
        next_dummy = 1'b1; // RULE6
      else if (dummy)
        next_dummy = 1'b0;
    end
    if (phase == PH_T1) begin
      // Fetch word at pc; pc steps to next word in same phase, or loads redirect in a dummy cycle
      if (dummy) begin
        next_instr = i_pmem_data;
        next_valid = 1'b0; // RULE9
        next_pc    = redirect; // RULE8
      end else begin
        next_instr = i_pmem_data; // RULE2
        next_valid = 1'b1; // RULE5
        next_pc    = pc + `FES_PC_WIDTH'(1); // RULE7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase    <= PH_T1;
      pc       <= `FES_PC_RESET; // RULE15
      instr    <= '0;
      valid    <= 1'b0;
      dummy    <= 1'b0;
      redirect <= `FES_PC_RESET;
      stack    <= '{default: '0};
      sp       <= '0;
      acc      <= '0;
    end else if (i_ce) begin
      phase    <= next_phase; // RULE1
      pc       <= next_pc;
      instr    <= next_instr;
      valid    <= next_valid;
      dummy    <= next_dummy;
      redirect <= next_redirect;
      stack    <= next_stack;
      sp       <= next_sp;
      acc      <= next_acc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    o_phase = '0;
    o_phase[phase] = 1'b1; // RULE1
  end
  assign o_cycle_start = (phase == PH_T1);
  assign o_pmem_addr   = pc;
  assign o_pmem_fetch  = (phase == PH_T1) && i_ce; // RULE2
  assign o_exec_instr  = instr;
  assign o_exec_valid  = valid && !dummy;
  assign o_acc         = acc;
  assign o_pcl         = pc[7:0]; // RULE10

endmodule
`default_nettype wire

// File: logic/fetch_execute_sequencer_params.svh
`ifndef FETCH_EXECUTE_SEQUENCER_PARAMS_SVH
`define FETCH_EXECUTE_SEQUENCER_PARAMS_SVH

`define FES_PC_WIDTH      11
`define FES_PC_RESET      11'h000
`define FES_INSTR_WIDTH   16
`define FES_DATA_WIDTH    8
`define FES_STACK_DEPTH   4
`define FES_SP_WIDTH      2
`define FES_PHASES        4

`endif

// File: logic/fetch_execute_sequencer_pkg.sv
package fetch_execute_sequencer_pkg;

  // Phase of the instruction cycle, one system clock each
  typedef enum logic [1:0] {
    PH_T1 = 2'b00,
    PH_T2 = 2'b01,
    PH_T3 = 2'b10,
    PH_T4 = 2'b11
  } phase_e;

  // Flow decision made by the decoder during phases two to four
  typedef enum logic [2:0] {
    FLOW_SEQ  = 3'b000,
    FLOW_JUMP = 3'b001,
    FLOW_CALL = 3'b010,
    FLOW_RET  = 3'b011,
    FLOW_SKIP = 3'b100,
    FLOW_PCLW = 3'b101,
    FLOW_INT  = 3'b110
  } flow_e;

  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_SUB = 3'b001,
    ALU_AND = 3'b010,
    ALU_OR  = 3'b011,
    ALU_XOR = 3'b100,
    ALU_RL  = 3'b101,
    ALU_RR  = 3'b110,
    ALU_INC = 3'b111
  } alu_op_e;

  // Execute request from decoder for the instruction in the execute slot
  typedef struct packed {
    flow_e       flow;
    logic [10:0] target;
    logic        skip_cond;
    alu_op_e     alu_op;
    logic [7:0]  operand;
    logic        acc_write;
    logic        pcl_read;
  } exec_req_s;

endpackage
